// ### hw/isb_pkg.sv
// Package with widths, constants and enumerations of the skip/branch/OR execution block.
package isb_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ISB_DATA_W = 8;
    localparam int ISB_ADDR_W = 7;
    localparam int ISB_PC_W = 13;
    localparam int ISB_K_W = 11;
    localparam int ISB_FILE_DEPTH = 128;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ISB_PAGE_HI = 4;
    localparam int ISB_PAGE_LO = 3;
    localparam int ISB_LIT_HI = 7;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic ISB_DEST_ACC = 1'h0;
    localparam logic ISB_DEST_FILE = 1'h1;
    localparam logic [ISB_DATA_W-1:0] ISB_ONE = 8'h01;
    localparam logic [ISB_DATA_W-1:0] ISB_ZERO = 8'h00;
    localparam logic [ISB_DATA_W-1:0] ISB_ACC_RST = 8'h00;
    localparam logic ISB_ZFLAG_RST = 1'h0;
    localparam logic [ISB_PC_W-1:0] ISB_PC_RST = 13'h0000;
    localparam logic [ISB_PC_W-1:0] ISB_PC_STEP = 13'h0001;
    localparam logic [ISB_PC_W-1:0] ISB_PC_SKIP = 13'h0002;
    localparam logic [ISB_ADDR_W-1:0] ISB_ADDR_RST = 7'h00;

    // ------------------------------------------------------------------
    // Operations and states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ISB_OP_NOP,
        ISB_OP_DECREMENT_SKIP_ZERO,
        ISB_OP_INCREMENT_SKIP_ZERO,
        ISB_OP_INCREMENT_FILE,
        ISB_OP_ABSOLUTE_BRANCH,
        ISB_OP_OR_LITERAL_ACCUMULATOR,
        ISB_OP_OR_ACCUMULATOR_FILE
    } isb_op_t;

    typedef enum logic {
        ISB_ST_EXEC,
        ISB_ST_FLUSH
    } isb_state_t;

endpackage

// ### hw/isb_alu_if.sv
// Interface carrying operands and results between the core and its arithmetic unit.
`timescale 1ns/1ps
interface isb_alu_if;
    import isb_pkg::*;

    isb_op_t op;
    logic [ISB_DATA_W-1:0] acc;
    logic [ISB_DATA_W-1:0] file_data;
    logic [ISB_DATA_W-1:0] lit;
    logic [ISB_DATA_W-1:0] result;
    logic upd_zero;
    logic result_zero;
    logic skip_req;
    logic has_dest;
    logic acc_only;
    logic branch;

    modport core (output op, output acc, output file_data, output lit,
                  input result, input upd_zero, input result_zero, input skip_req,
                  input has_dest, input acc_only, input branch);
    modport alu (input op, input acc, input file_data, input lit,
                 output result, output upd_zero, output result_zero, output skip_req,
                 output has_dest, output acc_only, output branch);
endinterface

// ### hw/isb_alu.sv
// Combinational arithmetic unit computing results, zero flag and skip requests.
`timescale 1ns/1ps
module isb_alu (
    isb_alu_if.alu bus
);
    import isb_pkg::*;

    logic [ISB_DATA_W-1:0] result;
    logic upd_zero;
    logic skip_op;
    logic has_dest;

    always_comb begin
        result = ISB_ZERO;
        upd_zero = 1'b0;
        skip_op = 1'b0;
        has_dest = 1'b0;
        case (bus.op)
            ISB_OP_DECREMENT_SKIP_ZERO: begin
                result = bus.file_data - ISB_ONE; // see [RULE1]
                skip_op = 1'b1;
                has_dest = 1'b1;
            end
            ISB_OP_INCREMENT_SKIP_ZERO: begin
                result = bus.file_data + ISB_ONE; // see [RULE4]
                skip_op = 1'b1;
                has_dest = 1'b1;
            end
            ISB_OP_INCREMENT_FILE: begin
                result = bus.file_data + ISB_ONE; // see [RULE9]
                upd_zero = 1'b1;
                has_dest = 1'b1;
            end
            ISB_OP_OR_LITERAL_ACCUMULATOR: begin
                result = bus.acc | bus.lit; // see [RULE8]
                upd_zero = 1'b1;
            end
            ISB_OP_OR_ACCUMULATOR_FILE: begin
                result = bus.acc | bus.file_data; // see [RULE10]
                upd_zero = 1'b1;
                has_dest = 1'b1;
            end
            default: begin
                result = ISB_ZERO;
            end
        endcase
    end

    assign bus.result = result;
    assign bus.upd_zero = upd_zero;
    assign bus.result_zero = (result == ISB_ZERO); // see [RULE11]
    assign bus.skip_req = skip_op && (result == ISB_ZERO); // see [RULE3]
    assign bus.has_dest = has_dest;
    assign bus.acc_only = (bus.op == ISB_OP_OR_LITERAL_ACCUMULATOR);
    assign bus.branch = (bus.op == ISB_OP_ABSOLUTE_BRANCH);

endmodule

// ### hw/isb_core.sv
// Execution core for skip-on-zero counting, absolute branch and inclusive OR operations.
// Summary of operation
// [RULE1] Decrement-and-skip subtracts one from file register 0..127; flags stay unchanged.
// [RULE2] Destination bit 0 writes the accumulator, 1 writes the file register.
// [RULE3] Zero skip result replaces the next instruction by a no-op: two cycles.
// [RULE4] Increment-and-skip adds one, skips on zero result, leaves flags unchanged.
// [RULE5] Absolute branch loads its 11-bit operand into program counter bits 10..0.
// [RULE6] Program counter bits 12..11 come from page latch bits 4..3.
// [RULE7] Absolute branch always takes two instruction cycles.
// [RULE8] Literal OR combines accumulator with 8-bit literal into accumulator, updates zero.
// [RULE9] Plain increment adds one, writes selected destination, updates zero, never skips.
// [RULE10] Register OR combines accumulator and file register into destination, updates zero.
// [RULE11] Zero flag is set when the 8-bit result is zero, else cleared.
`timescale 1ns/1ps
module isb_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic instr_valid,
    input wire isb_pkg::isb_op_t instr_op,
    input wire logic [isb_pkg::ISB_ADDR_W-1:0] instr_file,
    input wire logic instr_dest,
    input wire logic [isb_pkg::ISB_K_W-1:0] instr_k,
    output logic instr_ready_q,
    // Page latch register contents
    input wire logic [isb_pkg::ISB_DATA_W-1:0] page_latch_register,
    // File register preload
    input wire logic load_en,
    input wire logic [isb_pkg::ISB_ADDR_W-1:0] load_addr,
    input wire logic [isb_pkg::ISB_DATA_W-1:0] load_data,
    // Architectural state
    output logic [isb_pkg::ISB_DATA_W-1:0] acc_q,
    output logic zero_flag_q,
    output logic [isb_pkg::ISB_PC_W-1:0] pc_q,
    // Observed file writes and inserted no-ops
    output logic file_wr_en_q,
    output logic [isb_pkg::ISB_ADDR_W-1:0] file_wr_addr_q,
    output logic [isb_pkg::ISB_DATA_W-1:0] file_wr_data_q,
    output logic nop_slot_q
);
    import isb_pkg::*;

    // ------------------------------------------------------------------
    // File register storage
    // ------------------------------------------------------------------
    // The file array is not reset; software is expected to preload what it uses.
    logic [ISB_DATA_W-1:0] file_mem [ISB_FILE_DEPTH];

    // ------------------------------------------------------------------
    // State and next values
    // ------------------------------------------------------------------
    isb_state_t state_q;
    isb_state_t state_d;
    logic [ISB_DATA_W-1:0] acc_d;
    logic zero_flag_d;
    logic [ISB_PC_W-1:0] pc_d;
    logic instr_ready_d;
    logic file_wr_en_d;
    logic [ISB_ADDR_W-1:0] file_wr_addr_d;
    logic [ISB_DATA_W-1:0] file_wr_data_d;
    logic nop_slot_d;

    // ------------------------------------------------------------------
    // Arithmetic unit
    // ------------------------------------------------------------------
    isb_alu_if alu_bus ();

    isb_alu u_alu (
        .bus (alu_bus)
    );

    // Gating on the registered ready keeps the first edge after reset from taking an instruction.
    wire logic exec_fire = (state_q == ISB_ST_EXEC) && instr_ready_q && instr_valid;
    wire logic [ISB_DATA_W-1:0] file_rd_data = file_mem[instr_file];

    assign alu_bus.op = exec_fire ? instr_op : ISB_OP_NOP;
    assign alu_bus.acc = acc_q;
    assign alu_bus.file_data = file_rd_data;
    assign alu_bus.lit = instr_k[ISB_LIT_HI:0];

    // ------------------------------------------------------------------
    // Destination decode
    // ------------------------------------------------------------------
    wire logic to_file = alu_bus.has_dest && (instr_dest == ISB_DEST_FILE); // see [RULE2]
    wire logic to_acc = (alu_bus.has_dest && (instr_dest == ISB_DEST_ACC))
        || alu_bus.acc_only; // see [RULE2]

    // Core writes take priority over a preload aimed at the same cycle.
    wire logic mem_we = to_file || load_en;
    wire logic [ISB_ADDR_W-1:0] mem_waddr = to_file ? instr_file : load_addr;
    wire logic [ISB_DATA_W-1:0] mem_wdata = to_file ? alu_bus.result : load_data;

    // ------------------------------------------------------------------
    // Program counter targets
    // ------------------------------------------------------------------
    wire logic [ISB_PC_W-1:0] branch_target = {
        page_latch_register[ISB_PAGE_HI:ISB_PAGE_LO], // see [RULE6]
        instr_k // see [RULE5]
    };
    wire logic [ISB_PC_W-1:0] pc_next_seq = pc_q + ISB_PC_STEP;
    wire logic [ISB_PC_W-1:0] pc_next_skip = pc_q + ISB_PC_SKIP;

    // Both a taken skip and a branch burn the following slot.
    wire logic need_flush = alu_bus.skip_req || alu_bus.branch; // see [RULE3] see [RULE7]

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        zero_flag_d = zero_flag_q;
        pc_d = pc_q;
        case (state_q)
            ISB_ST_EXEC: begin
                if (exec_fire) begin
                    if (alu_bus.branch) begin
                        pc_d = branch_target; // see [RULE5]
                    end else if (alu_bus.skip_req) begin
                        pc_d = pc_next_skip; // see [RULE3]
                    end else begin
                        pc_d = pc_next_seq;
                    end
                    if (to_acc) begin
                        acc_d = alu_bus.result;
                    end
                    // Skip operations never touch the flag, so upd_zero gates it.
                    if (alu_bus.upd_zero) begin
                        zero_flag_d = alu_bus.result_zero; // see [RULE11]
                    end
                    if (need_flush) begin
                        state_d = ISB_ST_FLUSH;
                    end
                end
            end
            ISB_ST_FLUSH: begin
                // The slot after a skip or branch executes as a no-op.
                state_d = ISB_ST_EXEC; // see [RULE3] see [RULE7]
            end
            default: begin
                state_d = ISB_ST_EXEC;
            end
        endcase
    end

    assign instr_ready_d = (state_d == ISB_ST_EXEC);
    assign nop_slot_d = exec_fire && need_flush;
    assign file_wr_en_d = to_file;
    assign file_wr_addr_d = to_file ? instr_file : file_wr_addr_q;
    assign file_wr_data_d = to_file ? alu_bus.result : file_wr_data_q;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // One short process per register, with write address and data sharing one, keeps each reset value next to its flop.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ISB_ST_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= ISB_ACC_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_flag_q <= ISB_ZFLAG_RST;
        end else begin
            zero_flag_q <= zero_flag_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= ISB_PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    // Ready stays low through reset so the issuer cannot race the release.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_ready_q <= 1'b0;
        end else begin
            instr_ready_q <= instr_ready_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nop_slot_q <= 1'b0;
        end else begin
            nop_slot_q <= nop_slot_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr_en_q <= 1'b0;
        end else begin
            file_wr_en_q <= file_wr_en_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr_addr_q <= ISB_ADDR_RST;
            file_wr_data_q <= ISB_ZERO;
        end else begin
            file_wr_addr_q <= file_wr_addr_d;
            file_wr_data_q <= file_wr_data_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            file_mem[mem_waddr] <= mem_wdata; // see [RULE1] see [RULE2]
        end
    end

endmodule

// ### verif/isb_core_properties.sv
// Concurrent checks on the ports of the skip, branch and OR execution core.
`timescale 1ns/1ps
module isb_core_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic instr_valid,
    input wire isb_pkg::isb_op_t instr_op,
    input wire logic [isb_pkg::ISB_ADDR_W-1:0] instr_file,
    input wire logic instr_dest,
    input wire logic [isb_pkg::ISB_K_W-1:0] instr_k,
    input wire logic instr_ready_q,
    input wire logic [isb_pkg::ISB_DATA_W-1:0] page_latch_register,
    // Architectural state and observed writes
    input wire logic [isb_pkg::ISB_DATA_W-1:0] acc_q,
    input wire logic zero_flag_q,
    input wire logic [isb_pkg::ISB_PC_W-1:0] pc_q,
    input wire logic file_wr_en_q,
    input wire logic [isb_pkg::ISB_ADDR_W-1:0] file_wr_addr_q,
    input wire logic nop_slot_q
);
    import isb_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire take = instr_valid && instr_ready_q;
    wire skip_op = instr_op inside {ISB_OP_DECREMENT_SKIP_ZERO, ISB_OP_INCREMENT_SKIP_ZERO};
    wire file_op = skip_op || instr_op inside {ISB_OP_INCREMENT_FILE, ISB_OP_OR_ACCUMULATOR_FILE};
    wire is_branch = instr_op == ISB_OP_ABSOLUTE_BRANCH;
    wire z_acc = instr_op inside {ISB_OP_INCREMENT_FILE, ISB_OP_OR_ACCUMULATOR_FILE};
    wire is_or_lit = instr_op == ISB_OP_OR_LITERAL_ACCUMULATOR;
    wire is_inc = instr_op == ISB_OP_INCREMENT_FILE;
    wire z_write = z_acc && !instr_dest || is_or_lit;

    a_branch_target: assert property (take && is_branch |=> pc_q ==
        {$past(page_latch_register[ISB_PAGE_HI:ISB_PAGE_LO]), $past(instr_k)})
        else $error("bad target");
    a_branch_two_cycles: assert property (take && is_branch |=>
        (!instr_ready_q && nop_slot_q) ##1 instr_ready_q) else $error("branch not two cycles");
    a_skip_pc_step: assert property (take && skip_op |=>
        (pc_q - $past(pc_q)) == (instr_ready_q ? ISB_PC_STEP : ISB_PC_SKIP))
        else $error("bad step");
    a_skip_slot_nop: assert property (take && skip_op ##1 !instr_ready_q |->
        nop_slot_q ##1 instr_ready_q) else $error("skip slot wrong");
    a_flag_kept: assert property (take && (skip_op || is_branch) |=>
        $stable(zero_flag_q)) else $error("flag changed");
    a_literal_or: assert property (take && is_or_lit |=>
        acc_q == ($past(acc_q) | $past(instr_k[ISB_LIT_HI:0]))) else $error("bad literal or");
    a_zero_flag_value: assert property (take && z_write |=>
        zero_flag_q == (acc_q == ISB_ZERO)) else $error("bad zero flag");
    a_file_dest_write: assert property (take && instr_dest && file_op |=>
        file_wr_en_q && file_wr_addr_q == $past(instr_file)) else $error("file not written");
    a_acc_dest_quiet: assert property (take && !instr_dest && file_op |=>
        !file_wr_en_q) else $error("file written for accumulator");
    a_inc_never_skips: assert property (take && is_inc |=>
        instr_ready_q) else $error("increment skipped");

    c_branch: cover property (take && is_branch);
    c_skip_taken: cover property (take && skip_op ##1 !instr_ready_q);
    c_or_file: cover property (take && instr_op == ISB_OP_OR_ACCUMULATOR_FILE && instr_dest);
endmodule

bind isb_core isb_core_properties u_props (.ref_clk, .rst_n, .instr_valid, .instr_op,
    .instr_file, .instr_dest, .instr_k, .instr_ready_q, .page_latch_register, .acc_q,
    .zero_flag_q, .pc_q, .file_wr_en_q, .file_wr_addr_q, .nop_slot_q);

// ### verif/test_isb_core.sv
// Self-checking testbench of the skip, branch and OR execution core.
`timescale 1ns/1ps
module test_isb_core;
    import isb_pkg::*;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic instr_valid = 1'h0;
    isb_op_t instr_op = ISB_OP_NOP;
    logic [ISB_ADDR_W-1:0] instr_file = 7'h00;
    logic instr_dest = 1'h0;
    logic [ISB_K_W-1:0] instr_k = 11'h000;
    logic [ISB_DATA_W-1:0] page = 8'hEF;
    logic load_en = 1'h0;
    logic [ISB_ADDR_W-1:0] load_addr = 7'h00;
    logic [ISB_DATA_W-1:0] load_data = 8'h00;
    logic rdy, zf, wr_en, nop;
    logic [ISB_DATA_W-1:0] acc, wr_data;
    logic [ISB_ADDR_W-1:0] wr_addr;
    logic [ISB_PC_W-1:0] pc;
    int bad_count = 0;
    int num_checks = 0;

    isb_core DUT (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_file(instr_file), .instr_dest(instr_dest),
        .instr_k(instr_k), .instr_ready_q(rdy), .page_latch_register(page), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data), .acc_q(acc), .zero_flag_q(zf),
        .pc_q(pc), .file_wr_en_q(wr_en), .file_wr_addr_q(wr_addr), .file_wr_data_q(wr_data),
        .nop_slot_q(nop));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic preload(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        load_en <= 1'h1;
        load_addr <= a;
        load_data <= d;
        @(posedge ref_clk);
        load_en <= 1'h0;
    endtask

    // The instruction is held through any refused slot, as the core ignores it there.
    task automatic run(input isb_op_t op, input logic [6:0] f, input logic d,
        input logic [10:0] k, input logic [7:0] e_acc, input logic e_z, input logic [12:0] e_pc,
        input logic e_rdy, input logic e_wr, input logic [7:0] e_dat);
        logic r;
        int n;
        r = 1'h0;
        @(posedge ref_clk);
        instr_valid <= 1'h1;
        instr_op <= op;
        instr_file <= f;
        instr_dest <= d;
        instr_k <= k;
        for (n = 0; n < 20 && !r; n++) begin
            @(negedge ref_clk);
            r = (rdy === 1'h1);
            @(posedge ref_clk);
        end
        instr_valid <= 1'h0;
        if (!r) begin
            bad_count++;
            end_of_test();
        end
        // Write and no-op pulses stand only in the cycle right after the taking edge.
        @(negedge ref_clk);
        check(acc, e_acc);
        check(zf, e_z);
        check(pc, e_pc);
        check(rdy, e_rdy);
        check(wr_en, e_wr);
        check(nop, !e_rdy);
        if (e_wr) check(wr_data, e_dat);
        if (e_wr) check(wr_addr, f);
    endtask

    task automatic sc_or_literal;
        run(ISB_OP_OR_LITERAL_ACCUMULATOR, 7'h00, 1'h1, 11'h700, 8'h00, 1'h1, 13'h0001, 1'h1,
            1'h0, 8'h00);
        run(ISB_OP_OR_LITERAL_ACCUMULATOR, 7'h00, 1'h0, 11'h05A, 8'h5A, 1'h0, 13'h0002, 1'h1,
            1'h0, 8'h00);
    endtask

    task automatic sc_skip;
        preload(7'h05, 8'h01);
        run(ISB_OP_DECREMENT_SKIP_ZERO, 7'h05, 1'h1, 11'h000, 8'h5A, 1'h0, 13'h0004, 1'h0,
            1'h1, 8'h00);
        run(ISB_OP_DECREMENT_SKIP_ZERO, 7'h05, 1'h0, 11'h000, 8'hFF, 1'h0, 13'h0005, 1'h1,
            1'h0, 8'h00);
        preload(7'h7F, 8'hFF);
        run(ISB_OP_INCREMENT_SKIP_ZERO, 7'h7F, 1'h0, 11'h000, 8'h00, 1'h0, 13'h0007, 1'h0,
            1'h0, 8'h00);
    endtask

    task automatic sc_inc_or_file;
        run(ISB_OP_INCREMENT_FILE, 7'h7F, 1'h1, 11'h000, 8'h00, 1'h1, 13'h0008, 1'h1,
            1'h1, 8'h00);
        run(ISB_OP_INCREMENT_FILE, 7'h7F, 1'h0, 11'h000, 8'h01, 1'h0, 13'h0009, 1'h1,
            1'h0, 8'h00);
        preload(7'h03, 8'h80);
        run(ISB_OP_OR_ACCUMULATOR_FILE, 7'h03, 1'h1, 11'h000, 8'h01, 1'h0, 13'h000A, 1'h1,
            1'h1, 8'h81);
        run(ISB_OP_OR_ACCUMULATOR_FILE, 7'h05, 1'h0, 11'h000, 8'h01, 1'h0, 13'h000B, 1'h1,
            1'h0, 8'h00);
    endtask

    // A plain no-op after the branch only steps the counter and touches nothing else.
    task automatic sc_branch;
        run(ISB_OP_ABSOLUTE_BRANCH, 7'h00, 1'h1, 11'h5A5, 8'h01, 1'h0, 13'h0DA5, 1'h0,
            1'h0, 8'h00);
        run(ISB_OP_NOP, 7'h00, 1'h1, 11'h000, 8'h01, 1'h0, 13'h0DA6, 1'h1,
            1'h0, 8'h00);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'h1;
        sc_or_literal();
        sc_skip();
        sc_inc_or_file();
        sc_branch();
        end_of_test();
    end
endmodule
